//--- pcm_highway_port_timing_test.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_highway_port_timing_test;
	import pcmh_pkg::*;
	typedef struct packed {
		logic [10:0] bits;
		pcmh_rate_e  rate;
		logic [2:0]  sh;
		logic [6:0]  slot;
		logic [7:0]  data;
	} pcmh_row_s;
	logic         clk, rst_n, msl, msh, mclk, fs, txa, oea, txb, oeb, rxa, rxb, lock;
	logic [10:0]  bits, pos;
	logic [7:0]   da, db, b;
	pcmh_offset_s off;
	pcmh_slot_s   tsa, tsb;
	pcmh_rx_s     ra, rb;
	pcmh_rate_e   rate;
	int           error_cnt = 0;
	int           n_tests = 0;
	int           n;
	pcmh_row_s    rows [5] = '{'{11'h0c0, PCMH_RATE_1536, 3'h0, 7'h00, 8'h81},
		'{11'h0c1, PCMH_RATE_1536, 3'h5, 7'h15, 8'h3c}, '{11'h100, PCMH_RATE_2048, 3'h7, 7'h1d, 8'h5a},
		'{11'h200, PCMH_RATE_4096, 3'h3, 7'h3d, 8'hc3}, '{11'h400, PCMH_RATE_8192, 3'h7, 7'h7d, 8'he7}};
	pcmh_backplane bp (.clk(clk), .bits(bits), .mclk(mclk), .fs(fs), .pos(pos),
		.tx_a(txa), .oe_n_a(oea), .tx_b(txb), .oe_n_b(oeb), .rx_a(rxa), .rx_b(rxb));
	pcmh_port dut (.SYS_CLK(clk), .RESET_N(rst_n), .MODE_SELECT_LOW(msl), .MODE_SELECT_HIGH(msh),
		.MCLK_IN(mclk), .FRAME_SYNC_IN(fs), .FRAME_OFFSET_REG(off), .TX_SLOT_A(tsa), .RX_SLOT_A(tsa),
		.TX_SLOT_B(tsb), .RX_SLOT_B(tsb), .TX_DATA_A(da), .TX_DATA_B(db), .TX_TAKE_A(), .TX_TAKE_B(),
		.RX_A(ra), .RX_B(rb), .PCM_RX_IN_A(rxa), .PCM_TX_OUT_A(txa), .PCM_TX_OUT_A_OE_N(oea),
		.TX_SLOT_ENABLE_A(), .TX_SLOT_ENABLE_A_OE_N(), .PCM_RX_IN_B(rxb), .PCM_TX_OUT_B(txb),
		.PCM_TX_OUT_B_OE_N(oeb), .TX_SLOT_ENABLE_B(), .TX_SLOT_ENABLE_B_OE_N(), .RATE(rate), .RATE_LOCKED(lock));
	task chk(input logic [10:0] got, input logic [10:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task lock_on(input pcmh_rate_e r);
		n = 0;
		do @(negedge clk); while (lock !== 1'b0 && ++n < 20000);
		chk(lock, 1'b0);
		n = 0;
		do @(negedge clk); while (!(lock === 1'b1 && rate === r) && ++n < 40000);
		chk(lock, 1'b1);
		chk(rate, r);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#300000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		{rst_n, msl, off, tsa, tsb, da, db} = '0;
		msh = 1'b1;
		bits = 11'h100;
		repeat (2) @(negedge clk);
		chk(oea, 1'b1);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			bits = rows[i].bits;
			tsa = '0;
			tsb = '0;
			lock_on(rows[i].rate);
			off = '{rows[i].sh, rows[i].sh};
			da = rows[i].data;
			db = ~rows[i].data;
			tsa = '{1'b1, rows[i].slot};
			tsb = '{1'b1, rows[i].slot + 7'h01};
			n = 0;
			do @(negedge clk); while (oea !== 1'b0 && ++n < 40000);
			chk(pos, {rows[i].slot, rows[i].sh});
			for (int k = 0; k < 8; k++) begin
				@(negedge mclk);
				b = {b[6:0], txa};
			end
			chk(b, da);
			n = 0;
			do @(negedge clk); while (ra.valid !== 1'b1 && ++n < 400);
			chk(ra.valid, 1'b1);
			chk(ra.data, da);
			n = 0;
			do @(negedge clk); while (rb.valid !== 1'b1 && ++n < 400);
			chk(rb.valid, 1'b1);
			chk(rb.data, db);
		end
		msh = 1'b0;
		repeat (2) @(negedge clk);
		chk(lock, 1'b0);
		msh = 1'b1;
		tsa = '0;
		tsb = '0;
		lock_on(PCMH_RATE_8192);
		n = 0;
		repeat (2000) @(negedge clk) if (oea !== 1'b1) n++;
		chk(n[10:0], 11'h000);
		tally_and_finish();
	end
endmodule
`default_nettype wire

//--- pcmh_backplane.sv
`timescale 1ns/1ps
`default_nettype none
module pcmh_backplane (
	// Frame timing
	input  wire logic        clk,
	input  wire logic [10:0] bits,
	output logic             mclk,
	output logic             fs,
	output logic [10:0]      pos,
	// Loopback of both ports
	input  wire logic        tx_a,
	input  wire logic        oe_n_a,
	input  wire logic        tx_b,
	input  wire logic        oe_n_b,
	output logic             rx_a,
	output logic             rx_b
);
	logic div = 1'b0;
	initial begin
		{mclk, fs, rx_a, rx_b} = 4'h0;
		pos = 11'h000;
	end
	// Released line toggles so a stale bit is never read
	always @(negedge clk) begin
		div <= ~div;
		if (div) begin
			mclk <= ~mclk;
			if (!mclk) pos <= (pos >= bits - 11'h001) ? 11'h000 : pos + 11'h001;
			else fs <= (pos >= bits - 11'h001);
		end
		rx_a <= oe_n_a ? ~rx_a : tx_a;
		rx_b <= oe_n_b ? ~rx_b : tx_b;
	end
endmodule
`default_nettype wire

//--- pcmh_pkg.sv
`default_nettype none
package pcmh_pkg;

	typedef enum logic [2:0] {
		PCMH_RATE_NONE,
		PCMH_RATE_1536,
		PCMH_RATE_2048,
		PCMH_RATE_4096,
		PCMH_RATE_8192
	} pcmh_rate_e;

	typedef struct packed {
		logic       en;
		logic [6:0] slot;
	} pcmh_slot_s;

	typedef struct packed {
		logic [2:0] rx_shift;
		logic [2:0] tx_shift;
	} pcmh_offset_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} pcmh_rx_s;

endpackage
`default_nettype wire

//--- pcmh_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcmh_regs.svh"
module pcmh_port
	import pcmh_pkg::*;
(
	// Clock and reset
	input  wire logic         SYS_CLK,
	input  wire logic         RESET_N,
	// Mode pins
	input  wire logic         MODE_SELECT_LOW,
	input  wire logic         MODE_SELECT_HIGH,
	// Backplane timing
	input  wire logic         MCLK_IN,
	input  wire logic         FRAME_SYNC_IN,
	// Configuration
	input  wire pcmh_offset_s FRAME_OFFSET_REG,
	input  wire pcmh_slot_s   TX_SLOT_A,
	input  wire pcmh_slot_s   RX_SLOT_A,
	input  wire pcmh_slot_s   TX_SLOT_B,
	input  wire pcmh_slot_s   RX_SLOT_B,
	// Transmit data source
	input  wire logic [7:0]   TX_DATA_A,
	input  wire logic [7:0]   TX_DATA_B,
	output logic              TX_TAKE_A,
	output logic              TX_TAKE_B,
	// Receive data sink
	output var pcmh_rx_s      RX_A,
	output var pcmh_rx_s      RX_B,
	// Port A pins
	input  wire logic         PCM_RX_IN_A,
	output logic              PCM_TX_OUT_A,
	output logic              PCM_TX_OUT_A_OE_N,
	output logic              TX_SLOT_ENABLE_A,
	output logic              TX_SLOT_ENABLE_A_OE_N,
	// Port B pins
	input  wire logic         PCM_RX_IN_B,
	output logic              PCM_TX_OUT_B,
	output logic              PCM_TX_OUT_B_OE_N,
	output logic              TX_SLOT_ENABLE_B,
	output logic              TX_SLOT_ENABLE_B_OE_N,
	// Status
	output var pcmh_rate_e    RATE,
	output logic              RATE_LOCKED
);

	logic        run;
	logic        mclk_q;
	logic        fs_q;
	logic        fs_pending;
	logic        mclk_rise;
	logic        mclk_fall;
	logic        frame_start;
	logic [10:0] pos;
	logic [10:0] next_pos;
	logic        framed;
	logic        locked;

	logic [1:0]  rx_pin;
	logic [7:0]  tx_byte [2];
	pcmh_slot_s  tx_cfg  [2];
	pcmh_slot_s  rx_cfg  [2];

	// Only pattern 10 runs; 00 and the forbidden patterns hold reset
	always_comb run = RESET_N && ({MODE_SELECT_HIGH, MODE_SELECT_LOW} == `PCMH_MODE_NORMAL);

	// ****************************************
	// Edge detection on backplane signals
	// ****************************************
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			mclk_q <= 1'b0;
			fs_q   <= 1'b0;
		end else begin
			mclk_q <= MCLK_IN;
			fs_q   <= FRAME_SYNC_IN;
		end
	end

	always_comb begin
		mclk_rise   = MCLK_IN && !mclk_q;
		mclk_fall   = !MCLK_IN && mclk_q;
		frame_start = mclk_rise && (fs_pending || (FRAME_SYNC_IN && !fs_q));
	end

	always_ff @(posedge SYS_CLK) begin
		if (!run) begin
			fs_pending <= 1'b0;
		end else if (frame_start) begin
			fs_pending <= 1'b0;
		end else if (FRAME_SYNC_IN && !fs_q) begin
			fs_pending <= 1'b1;
		end
	end

	// ****************************************
	// Common bit position within the frame
	// ****************************************
	always_comb begin
		next_pos = pos;
		if (frame_start) begin
			next_pos = 11'h000;
		end else if (mclk_rise && pos != `PCMH_POS_MAX) begin
			next_pos = pos + 11'h001;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!run) begin
			pos    <= `PCMH_POS_MAX;
			framed <= 1'b0;
		end else begin
			pos <= next_pos;
			if (frame_start) begin
				framed <= 1'b1;
			end
		end
	end

	pcmh_rate_det u_rate (
		.clk         (SYS_CLK),
		.run         (run),
		.mclk_rise   (mclk_rise),
		.frame_start (frame_start),
		.rate        (RATE),
		.stable      (RATE_LOCKED)
	);

	always_comb locked = RATE_LOCKED && framed;

	always_comb begin
		rx_pin    = {PCM_RX_IN_B, PCM_RX_IN_A};
		tx_byte[0] = TX_DATA_A;
		tx_byte[1] = TX_DATA_B;
		tx_cfg[0]  = TX_SLOT_A;
		tx_cfg[1]  = TX_SLOT_B;
		rx_cfg[0]  = RX_SLOT_A;
		rx_cfg[1]  = RX_SLOT_B;
	end

	// ****************************************
	// Per-port shifters, identical for A and B
	// ****************************************
	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			logic [10:0] tx_idx;
			logic [10:0] rx_idx;
			logic        tx_hit;
			logic        rx_hit;
			logic [7:0]  tx_sh;
			logic [7:0]  rx_sh;
			logic        tx_on;
			logic        rx_on;
			logic        dx_q;
			logic        oe_n_q;
			logic        take_q;
			pcmh_rx_s    rx_q;

			always_comb begin
				tx_idx = next_pos - {8'h00, FRAME_OFFSET_REG.tx_shift};
				rx_idx = pos - {8'h00, FRAME_OFFSET_REG.rx_shift};
				tx_hit = locked && tx_cfg[p].en && next_pos >= {8'h00, FRAME_OFFSET_REG.tx_shift}
					&& tx_idx[10:3] == {1'b0, tx_cfg[p].slot};
				rx_hit = locked && rx_cfg[p].en && pos >= {8'h00, FRAME_OFFSET_REG.rx_shift}
					&& pos != `PCMH_POS_MAX && rx_idx[10:3] == {1'b0, rx_cfg[p].slot};
			end

			// Transmit: bits change on the bit clock rising edge
			// A slot met part-way through (late lock or late enable) is skipped, never sent cut short
			always_ff @(posedge SYS_CLK) begin
				if (!run) begin
					dx_q   <= 1'b0;
					oe_n_q <= 1'b1;
					tx_sh  <= 8'h00;
					take_q <= 1'b0;
					tx_on  <= 1'b0;
				end else begin
					take_q <= 1'b0;
					if (!locked) begin
						oe_n_q <= 1'b1;
						tx_on  <= 1'b0;
					end else if (mclk_rise) begin
						if (tx_hit && tx_idx[2:0] == 3'h0) begin
							oe_n_q <= 1'b0;
							tx_on  <= 1'b1;
							dx_q   <= tx_byte[p][7];
							tx_sh  <= {tx_byte[p][6:0], 1'b0};
							take_q <= 1'b1;
						end else if (tx_hit && tx_on) begin
							dx_q  <= tx_sh[7];
							tx_sh <= {tx_sh[6:0], 1'b0};
						end else begin
							oe_n_q <= 1'b1;
							tx_on  <= 1'b0;
						end
					end
				end
			end

			// Receive: bits sampled on the bit clock falling edge, whole bytes only
			always_ff @(posedge SYS_CLK) begin
				if (!run) begin
					rx_sh <= 8'h00;
					rx_on <= 1'b0;
					rx_q  <= '0;
				end else begin
					rx_q.valid <= 1'b0;
					if (mclk_fall) begin
						if (rx_hit && (rx_idx[2:0] == 3'h0 || rx_on)) begin
							rx_sh <= {rx_sh[6:0], rx_pin[p]};
							rx_on <= (rx_idx[2:0] != 3'h7);
							if (rx_idx[2:0] == 3'h7) begin
								rx_q.data  <= {rx_sh[6:0], rx_pin[p]};
								rx_q.valid <= 1'b1;
							end
						end else begin
							rx_on <= 1'b0;
						end
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Pin outputs
	// ****************************************
	always_comb begin
		PCM_TX_OUT_A          = g_port[0].dx_q;
		PCM_TX_OUT_A_OE_N     = g_port[0].oe_n_q;
		PCM_TX_OUT_B          = g_port[1].dx_q;
		PCM_TX_OUT_B_OE_N     = g_port[1].oe_n_q;
		TX_SLOT_ENABLE_A      = 1'b0;
		TX_SLOT_ENABLE_A_OE_N = g_port[0].oe_n_q;
		TX_SLOT_ENABLE_B      = 1'b0;
		TX_SLOT_ENABLE_B_OE_N = g_port[1].oe_n_q;
		TX_TAKE_A             = g_port[0].take_q;
		TX_TAKE_B             = g_port[1].take_q;
		RX_A                  = g_port[0].rx_q;
		RX_B                  = g_port[1].rx_q;
	end

endmodule
`default_nettype wire

//--- pcmh_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pcmh_port_properties
	import pcmh_pkg::*;
(
	// Watched ports
	input wire logic       SYS_CLK,
	input wire logic       RESET_N,
	input wire logic       MODE_SELECT_LOW,
	input wire logic       MODE_SELECT_HIGH,
	input wire logic       MCLK_IN,
	input wire logic       PCM_TX_OUT_A,
	input wire logic       PCM_TX_OUT_A_OE_N,
	input wire logic       PCM_TX_OUT_B_OE_N,
	input wire logic       TX_SLOT_ENABLE_A_OE_N,
	input wire logic       TX_SLOT_ENABLE_B_OE_N,
	input wire logic       TX_SLOT_ENABLE_A,
	input wire logic       TX_SLOT_ENABLE_B,
	input wire logic       TX_TAKE_A,
	input wire logic       TX_TAKE_B,
	input wire pcmh_rx_s   RX_A,
	input wire pcmh_rate_e RATE,
	input wire logic       RATE_LOCKED
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	a_pair_a: assert property (TX_SLOT_ENABLE_A_OE_N == PCM_TX_OUT_A_OE_N)
		else $error("slot enable A");
	a_pair_b: assert property (TX_SLOT_ENABLE_B_OE_N == PCM_TX_OUT_B_OE_N)
		else $error("slot enable B");
	a_reset_quiet: assert property (disable iff (1'b0) !RESET_N |=> PCM_TX_OUT_A_OE_N && PCM_TX_OUT_B_OE_N)
		else $error("drive in reset");
	a_mode_hold: assert property ({MODE_SELECT_HIGH, MODE_SELECT_LOW} != 2'b10 |=> PCM_TX_OUT_A_OE_N && !RATE_LOCKED)
		else $error("mode reset");
	a_unlock_quiet: assert property (!RATE_LOCKED [*2] |-> PCM_TX_OUT_A_OE_N && PCM_TX_OUT_B_OE_N)
		else $error("drive unlocked");
	a_tx_rise: assert property ($fell(PCM_TX_OUT_A_OE_N) || (!PCM_TX_OUT_A_OE_N && $changed(PCM_TX_OUT_A))
		|-> $past(MCLK_IN) && !$past(MCLK_IN, 2)) else $error("tx edge");
	a_rx_pulse: assert property (RX_A.valid |=> !RX_A.valid)
		else $error("rx pulse");
	a_rate_known: assert property (RATE_LOCKED |-> RATE != PCMH_RATE_NONE)
		else $error("rate none");
	a_take_first_a: assert property ($fell(PCM_TX_OUT_A_OE_N) |-> TX_TAKE_A)
		else $error("take A");
	a_take_first_b: assert property ($fell(PCM_TX_OUT_B_OE_N) |-> TX_TAKE_B)
		else $error("take B");
	a_slot_pull_low: assert property (!TX_SLOT_ENABLE_A && !TX_SLOT_ENABLE_B)
		else $error("slot enable level");
	c_lock: cover property ($rose(RATE_LOCKED));
	c_tx: cover property ($fell(PCM_TX_OUT_A_OE_N));
	c_rx: cover property (RX_A.valid);
endmodule
bind pcmh_port pcmh_port_properties chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
	.MODE_SELECT_LOW(MODE_SELECT_LOW), .MODE_SELECT_HIGH(MODE_SELECT_HIGH), .MCLK_IN(MCLK_IN),
	.PCM_TX_OUT_A(PCM_TX_OUT_A), .PCM_TX_OUT_A_OE_N(PCM_TX_OUT_A_OE_N), .PCM_TX_OUT_B_OE_N(PCM_TX_OUT_B_OE_N),
	.TX_SLOT_ENABLE_A_OE_N(TX_SLOT_ENABLE_A_OE_N), .TX_SLOT_ENABLE_B_OE_N(TX_SLOT_ENABLE_B_OE_N),
	.TX_SLOT_ENABLE_A(TX_SLOT_ENABLE_A), .TX_SLOT_ENABLE_B(TX_SLOT_ENABLE_B),
	.TX_TAKE_A(TX_TAKE_A), .TX_TAKE_B(TX_TAKE_B),
	.RX_A(RX_A), .RATE(RATE), .RATE_LOCKED(RATE_LOCKED));
`default_nettype wire

//--- pcmh_rate_det.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcmh_regs.svh"
module pcmh_rate_det
	import pcmh_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       run,
	// Events
	input  wire logic       mclk_rise,
	input  wire logic       frame_start,
	// Result
	output var pcmh_rate_e  rate,
	output logic            stable
);

	logic [10:0] cnt;
	logic [10:0] last;

	function automatic pcmh_rate_e classify(input logic [10:0] n);
		unique case (n)
			`PCMH_BITS_1536, `PCMH_BITS_1544: classify = PCMH_RATE_1536;
			`PCMH_BITS_2048: classify = PCMH_RATE_2048;
			`PCMH_BITS_4096: classify = PCMH_RATE_4096;
			`PCMH_BITS_8192: classify = PCMH_RATE_8192;
			default: classify = PCMH_RATE_NONE;
		endcase
	endfunction

	// ****************************************
	// Bit clocks per frame
	// ****************************************
	always_ff @(posedge clk) begin
		if (!run) begin
			cnt  <= 11'h000;
			last <= 11'h000;
		end else if (frame_start) begin
			cnt  <= 11'h001;
			last <= cnt;
		end else if (mclk_rise && cnt != `PCMH_POS_MAX) begin
			cnt <= cnt + 11'h001;
		end
	end

	// ****************************************
	// Rate lock: two equal known counts in a row
	// ****************************************
	always_ff @(posedge clk) begin
		if (!run) begin
			rate   <= PCMH_RATE_NONE;
			stable <= 1'b0;
		end else if (frame_start) begin
			rate   <= classify(cnt);
			stable <= (cnt == last) && (classify(cnt) != PCMH_RATE_NONE);
		end else if (cnt == `PCMH_POS_MAX) begin
			stable <= 1'b0;
		end
	end

endmodule
`default_nettype wire

//--- pcmh_regs.svh
// Contract
// - Mode 00 resets, 10 runs, others forbidden
// - 8 kHz frame sync starts both frames
// - Frame start delayed 0-7 bits per direction
// - Master clock rate detected automatically
// - Master clock shifts all serial data
// - Slot indicator pulls low only during slot
// - Transmit data tri-stated outside slots, rising edge
// - Receive data sampled in slots, falling edge
// - Port B behaves exactly as port A
// - Reset tri-states outputs, no slots assigned
// - One frame sync serves both directions
`ifndef PCMH_REGS_SVH
`define PCMH_REGS_SVH

// ****************************************
// Mode pin patterns
// ****************************************
`define PCMH_MODE_RESET   2'b00
`define PCMH_MODE_NORMAL  2'b10

// ****************************************
// Bit clocks per frame for each rate
// ****************************************
`define PCMH_BITS_1536    11'h0c0
`define PCMH_BITS_1544    11'h0c1
`define PCMH_BITS_2048    11'h100
`define PCMH_BITS_4096    11'h200
`define PCMH_BITS_8192    11'h400
`define PCMH_POS_MAX      11'h7ff

`endif
